// ---- core/capture_reset_enable_defines.svh ----
// register map, field positions, reset values and tick divisors of the timer 2 block
`ifndef CAPTURE_RESET_ENABLE_DEFINES_SVH
`define CAPTURE_RESET_ENABLE_DEFINES_SVH

// register indices; byte address is four times the index
`define CAPTURE_RESET_ENABLE_IDX_CONTROL     8'hc8
`define CAPTURE_RESET_ENABLE_IDX_MODE        8'hc9
`define CAPTURE_RESET_ENABLE_IDX_CAP_LOW     8'hca
`define CAPTURE_RESET_ENABLE_IDX_CAP_HIGH    8'hcb
`define CAPTURE_RESET_ENABLE_IDX_COUNT_LOW   8'hcc
`define CAPTURE_RESET_ENABLE_IDX_COUNT_HIGH  8'hcd

// timer_two_control fields
`define CAPTURE_RESET_ENABLE_CTL_OVERFLOW    7
`define CAPTURE_RESET_ENABLE_CTL_EXTERNAL    6
`define CAPTURE_RESET_ENABLE_CTL_RX_BAUD     5
`define CAPTURE_RESET_ENABLE_CTL_TX_BAUD     4
`define CAPTURE_RESET_ENABLE_CTL_TRIG_EN     3
`define CAPTURE_RESET_ENABLE_CTL_RUN         2
`define CAPTURE_RESET_ENABLE_CTL_CT_SEL      1
`define CAPTURE_RESET_ENABLE_CTL_CP_RL       0

// timer_two_mode fields
`define CAPTURE_RESET_ENABLE_MOD_HC_HI       7
`define CAPTURE_RESET_ENABLE_MOD_HC_LO       4
`define CAPTURE_RESET_ENABLE_MOD_CAP_RESET   3
`define CAPTURE_RESET_ENABLE_MOD_CLK_OUT     1
`define CAPTURE_RESET_ENABLE_MOD_DOWN_EN     0
`define CAPTURE_RESET_ENABLE_MOD_WRITE_MASK  8'hfb

// reset values
`define CAPTURE_RESET_ENABLE_RST_CONTROL     8'h00
`define CAPTURE_RESET_ENABLE_RST_MODE        8'h00
`define CAPTURE_RESET_ENABLE_RST_CAPTURE     16'h0000
`define CAPTURE_RESET_ENABLE_RST_COUNT       16'h0000

// clocks per count tick
`define CAPTURE_RESET_ENABLE_DIV_SLOW        12
`define CAPTURE_RESET_ENABLE_DIV_FAST        4
`define CAPTURE_RESET_ENABLE_DIV_BAUD        2

`endif

// ---- core/capture_reset_enable_pkg.sv ----
// types shared by the timer 2 block
package capture_reset_enable_pkg;

	typedef enum logic [3:0] {
		CAPTURE_RESET_ENABLE_CAPTURE = 4'h1,
		CAPTURE_RESET_ENABLE_RELOAD  = 4'h2,
		CAPTURE_RESET_ENABLE_UPDOWN  = 4'h4,
		CAPTURE_RESET_ENABLE_BAUD    = 4'h8
	} capture_reset_enable_mode_type;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  mode;
		logic [15:0] cap;
		logic [15:0] cnt;
		logic [3:0]  pre;
		logic        wr_pend;
		logic [7:0]  wr_idx;
		logic [31:0] hrdata;
		logic        rx_tick;
		logic        tx_tick;
		logic        clk_out;
		logic        irq;
		logic [3:0]  irq_clr;
	} capture_reset_enable_state_type;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
	} capture_reset_enable_sync_type;

endpackage

// ---- core/capture_reset_enable_pin_sync.sv ----
// two-stage pin synchroniser with falling-edge detect
`timescale 1ns/1ps
module capture_reset_enable_pin_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// asynchronous pins
	input  wire logic [WIDTH-1:0] pin_in,
	// synchronised view
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] fall
);
	import capture_reset_enable_pkg::*;

	capture_reset_enable_sync_type q;
	capture_reset_enable_sync_type d;

	initial begin
		if (WIDTH != 2)
			$error("capture_reset_enable_pin_sync: WIDTH must be 2");
	end

	// s1 is read only by s2; edges are taken between s2 and s3
	always_comb begin
		d    = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge clk) begin
		if (srst)
			q <= '0;
		else
			q <= d;
	end

	assign level = q.s2;
	assign fall  = q.s3 & ~q.s2;
endmodule // capture_reset_enable_pin_sync

// ---- core/capture_reset_enable_timer.sv ----
// timer 2: 16-bit capture / auto-reload / up-down / baud-rate timer with an AHB-Lite register slave
//
// Overview of operation
// R1 - overflow, or down count hitting capture, sets flag
// R2 - hardware sets overflow flag only outside baud mode
// R3 - trigger fall sets external flag
// R4 - software or trigger setting external flag requests interrupt
// R5 - receive select picks timer overflow, forces baud
// R6 - transmit select picks timer overflow, forces baud
// R7 - trigger enable gates trigger pin outside baud mode
// R8 - run control stops counting, count preserved
// R9 - baud mode ticks every two clocks
// R10 - select chooses internal clocks or count-pin falls
// R11 - baud mode ignores capture select, always reloads
// R12 - reload on overflow or enabled trigger fall
// R13 - capture count on enabled trigger fall
// R14 - capture reset enable clears count after capture
// R15 - output enable gates the clock-out toggle
// R16 - down enable and trigger level set direction
// R17 - capture registers take count or supply reload
// R18 - hardware-clear bits clear irq 2-5 flags
// R19 - trigger high counts up, low counts down
// R20 - baud overflow reloads and pulses serial tick
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "capture_reset_enable_defines.svh"
module capture_reset_enable_timer #(
	parameter int DIV_SLOW = `CAPTURE_RESET_ENABLE_DIV_SLOW,
	parameter int DIV_FAST = `CAPTURE_RESET_ENABLE_DIV_FAST
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// pins
	input  wire logic        count_pin,
	input  wire logic        trigger_pin,
	// core side
	input  wire logic        timer_speed_bit,
	input  wire logic [3:0]  ext_irq_entry,
	output logic             timer_irq,
	output logic      [3:0]  ext_irq_flag_clear,
	output logic             rx_baud_tick,
	output logic             tx_baud_tick,
	output logic             rx_use_timer2,
	output logic             tx_use_timer2,
	output logic             clock_out
);
	import capture_reset_enable_pkg::*;

	capture_reset_enable_state_type q;
	capture_reset_enable_state_type d;
	capture_reset_enable_mode_type  tmode;
	logic [1:0]     pin_level;
	logic [1:0]     pin_fall;
	logic           baud;
	logic           run;
	logic           tick;
	logic           down;
	logic           ovf;
	logic           trig_event;
	logic           tf_set;
	logic           exf_set;
	logic [3:0]     pre_lim;
	logic           addr_ok;

	initial begin
		if (DIV_SLOW < 2 || DIV_SLOW > 16 || DIV_FAST < 2 || DIV_FAST > 16)
			$error("capture_reset_enable_timer: divisors must lie in 2..16");
	end

	// bit 0 is the count pin, bit 1 the trigger pin
	capture_reset_enable_pin_sync #(
		.WIDTH (2)
	) u_sync (
		.clk    (clk),
		.srst   (srst),
		.pin_in ({trigger_pin, count_pin}),
		.level  (pin_level),
		.fall   (pin_fall)
	);

	function automatic logic [31:0] rd_mux(input capture_reset_enable_state_type s, input logic [7:0] idx);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			`CAPTURE_RESET_ENABLE_IDX_CONTROL:    b = s.ctrl;
			`CAPTURE_RESET_ENABLE_IDX_MODE:       b = s.mode;
			`CAPTURE_RESET_ENABLE_IDX_CAP_LOW:    b = s.cap[7:0];
			`CAPTURE_RESET_ENABLE_IDX_CAP_HIGH:   b = s.cap[15:8];
			`CAPTURE_RESET_ENABLE_IDX_COUNT_LOW:  b = s.cnt[7:0];
			`CAPTURE_RESET_ENABLE_IDX_COUNT_HIGH: b = s.cnt[15:8];
			default:              b = 8'h00;
		endcase
		return {24'h000000, b};
	endfunction

	always_comb begin
		d          = q;
		d.rx_tick  = 1'b0;
		d.tx_tick  = 1'b0;
		d.irq_clr  = ext_irq_entry & q.mode[`CAPTURE_RESET_ENABLE_MOD_HC_HI:`CAPTURE_RESET_ENABLE_MOD_HC_LO]; // R18
		baud       = q.ctrl[`CAPTURE_RESET_ENABLE_CTL_RX_BAUD] | q.ctrl[`CAPTURE_RESET_ENABLE_CTL_TX_BAUD]; // R5 R6
		run        = q.ctrl[`CAPTURE_RESET_ENABLE_CTL_RUN];
		// baud select overrides the capture select
		if (baud)
			tmode = CAPTURE_RESET_ENABLE_BAUD; // R11
		else if (q.ctrl[`CAPTURE_RESET_ENABLE_CTL_CP_RL])
			tmode = CAPTURE_RESET_ENABLE_CAPTURE;
		else if (q.mode[`CAPTURE_RESET_ENABLE_MOD_DOWN_EN])
			tmode = CAPTURE_RESET_ENABLE_UPDOWN; // R16
		else
			tmode = CAPTURE_RESET_ENABLE_RELOAD;

		// prescaler; held while stopped so a restart keeps the phase
		if (baud)
			pre_lim = 4'(`CAPTURE_RESET_ENABLE_DIV_BAUD - 1); // R9
		else if (timer_speed_bit)
			pre_lim = 4'(DIV_FAST - 1); // R10
		else
			pre_lim = 4'(DIV_SLOW - 1);
		tick = 1'b0;
		if (run) begin // R8
			if (q.pre >= pre_lim)
				d.pre = 4'h0;
			else
				d.pre = q.pre + 4'h1;
			if (baud || !q.ctrl[`CAPTURE_RESET_ENABLE_CTL_CT_SEL])
				tick = (q.pre >= pre_lim); // R9 R10
			else
				tick = pin_fall[0]; // R10
		end

		down = (tmode == CAPTURE_RESET_ENABLE_UPDOWN) && !pin_level[1]; // R19
		if (down)
			ovf = tick && (q.cnt == q.cap); // R1
		else
			ovf = tick && (q.cnt == 16'hffff); // R1
		trig_event = pin_fall[1] && q.ctrl[`CAPTURE_RESET_ENABLE_CTL_TRIG_EN] &&
			(tmode == CAPTURE_RESET_ENABLE_CAPTURE || tmode == CAPTURE_RESET_ENABLE_RELOAD); // R7
		tf_set  = ovf && !baud; // R2 R20
		exf_set = trig_event; // R3

		// counting
		if (tick) begin
			if (ovf) begin
				case (tmode)
					CAPTURE_RESET_ENABLE_CAPTURE: d.cnt = 16'h0000;
					CAPTURE_RESET_ENABLE_RELOAD:  d.cnt = q.cap; // R12 R17
					CAPTURE_RESET_ENABLE_UPDOWN:  d.cnt = down ? 16'hffff : q.cap; // R19
					CAPTURE_RESET_ENABLE_BAUD:    d.cnt = q.cap; // R11 R20
					default:      d.cnt = q.cnt;
				endcase
			end else if (down) begin
				d.cnt = q.cnt - 16'h0001;
			end else begin
				d.cnt = q.cnt + 16'h0001;
			end
		end

		// trigger actions; a trigger takes precedence over a tick in the same cycle
		case (tmode)
			CAPTURE_RESET_ENABLE_CAPTURE: begin
				if (trig_event) begin
					d.cap = q.cnt; // R13 R17
					if (q.mode[`CAPTURE_RESET_ENABLE_MOD_CAP_RESET])
						d.cnt = 16'h0000; // R14
				end
			end
			CAPTURE_RESET_ENABLE_RELOAD: begin
				if (trig_event)
					d.cnt = q.cap; // R12
			end
			default: begin
			end
		endcase

		// flags: a hardware set wins over a software clear, but a write overrides the up-down toggle of the external flag
		if (tf_set)
			d.ctrl[`CAPTURE_RESET_ENABLE_CTL_OVERFLOW] = 1'b1; // R1
		if (exf_set)
			d.ctrl[`CAPTURE_RESET_ENABLE_CTL_EXTERNAL] = 1'b1; // R3
		else if (ovf && tmode == CAPTURE_RESET_ENABLE_UPDOWN)
			d.ctrl[`CAPTURE_RESET_ENABLE_CTL_EXTERNAL] = ~q.ctrl[`CAPTURE_RESET_ENABLE_CTL_EXTERNAL]; // R19

		if (ovf && baud) begin
			d.rx_tick = q.ctrl[`CAPTURE_RESET_ENABLE_CTL_RX_BAUD]; // R5 R20
			d.tx_tick = q.ctrl[`CAPTURE_RESET_ENABLE_CTL_TX_BAUD]; // R6 R20
		end
		if (ovf && q.mode[`CAPTURE_RESET_ENABLE_MOD_CLK_OUT])
			d.clk_out = ~q.clk_out; // R15

		// data phase of a write; software owns the written byte, except that an overflow or trigger flag set in the same cycle still wins
		if (q.wr_pend) begin
			case (q.wr_idx)
				`CAPTURE_RESET_ENABLE_IDX_CONTROL: begin
					d.ctrl = hwdata[7:0];
					d.ctrl[`CAPTURE_RESET_ENABLE_CTL_OVERFLOW] = hwdata[`CAPTURE_RESET_ENABLE_CTL_OVERFLOW] | tf_set; // R2
					d.ctrl[`CAPTURE_RESET_ENABLE_CTL_EXTERNAL] = hwdata[`CAPTURE_RESET_ENABLE_CTL_EXTERNAL] | exf_set; // R4
				end
				`CAPTURE_RESET_ENABLE_IDX_MODE:       d.mode = hwdata[7:0] & `CAPTURE_RESET_ENABLE_MOD_WRITE_MASK;
				`CAPTURE_RESET_ENABLE_IDX_CAP_LOW:    d.cap[7:0] = hwdata[7:0];
				`CAPTURE_RESET_ENABLE_IDX_CAP_HIGH:   d.cap[15:8] = hwdata[7:0];
				`CAPTURE_RESET_ENABLE_IDX_COUNT_LOW:  d.cnt[7:0] = hwdata[7:0];
				`CAPTURE_RESET_ENABLE_IDX_COUNT_HIGH: d.cnt[15:8] = hwdata[7:0];
				default: begin
				end
			endcase
		end

		// address phase; read data is taken from the next state so a
		// read right after a write sees the written value
		addr_ok   = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
		d.wr_pend = 1'b0;
		if (hsel && htrans[1] && hready) begin
			d.wr_pend = hwrite && addr_ok;
			d.wr_idx  = haddr[9:2];
			d.hrdata  = addr_ok ? rd_mux(d, haddr[9:2]) : 32'h00000000;
		end
		d.irq = d.ctrl[`CAPTURE_RESET_ENABLE_CTL_OVERFLOW] | d.ctrl[`CAPTURE_RESET_ENABLE_CTL_EXTERNAL]; // R4
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q      <= '0;
			q.ctrl <= `CAPTURE_RESET_ENABLE_RST_CONTROL;
			q.mode <= `CAPTURE_RESET_ENABLE_RST_MODE;
			q.cap  <= `CAPTURE_RESET_ENABLE_RST_CAPTURE;
			q.cnt  <= `CAPTURE_RESET_ENABLE_RST_COUNT;
		end else begin
			q <= d;
		end
	end

	// zero-wait slave: ready and okay are constant flops
	logic ready_q;
	always_ff @(posedge clk) begin
		if (srst)
			ready_q <= 1'b1;
		else
			ready_q <= 1'b1;
	end

	assign hreadyout          = ready_q;
	assign hresp              = 1'b0 & ready_q;
	assign hrdata             = q.hrdata;
	assign timer_irq          = q.irq;
	assign ext_irq_flag_clear = q.irq_clr;
	assign rx_baud_tick       = q.rx_tick;
	assign tx_baud_tick       = q.tx_tick;
	assign rx_use_timer2      = q.ctrl[`CAPTURE_RESET_ENABLE_CTL_RX_BAUD];
	assign tx_use_timer2      = q.ctrl[`CAPTURE_RESET_ENABLE_CTL_TX_BAUD];
	assign clock_out          = q.clk_out;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	overflow_sets_flag_a: assert property (tf_set |=> q.ctrl[7]) // R1
		else $error("overflow did not set overflow flag");
	baud_no_flag_a: assert property (baud && !q.wr_pend && !q.ctrl[7] |=> !q.ctrl[7]) // R2
		else $error("overflow flag set in baud mode");
	trigger_sets_ext_a: assert property (trig_event |=> q.ctrl[6] ##0 q.irq) // R3
		else $error("trigger fall did not set external flag and interrupt");
	ext_flag_irq_a: assert property ($rose(q.ctrl[6]) |-> q.irq) // R4
		else $error("external flag without interrupt request");
	halt_holds_a: assert property (!run && !q.wr_pend && !trig_event |=> $stable(q.cnt)) // R8
		else $error("count moved while stopped");
	baud_rate_a: assert property (baud && run && $stable(q.ctrl) && tick |=> !tick ##1 tick) // R9
		else $error("baud tick not every two clocks");
	ignore_trigger_a: assert property (!q.ctrl[3] |-> !trig_event) // R7
		else $error("trigger acted while disabled");
	capture_copy_a: assert property (trig_event && tmode == CAPTURE_RESET_ENABLE_CAPTURE && !q.wr_pend |=> q.cap == $past(q.cnt)) // R13
		else $error("capture register missed count");
	reload_ovf_a: assert property (ovf && tmode == CAPTURE_RESET_ENABLE_RELOAD && !trig_event && !q.wr_pend
		|=> q.cnt == $past(q.cap)) // R12
		else $error("no reload on overflow");
	baud_tick_a: assert property (ovf && q.ctrl[5] |=> rx_baud_tick ##1 !rx_baud_tick) // R20
		else $error("receive baud tick missing");
	hw_clear_a: assert property (ext_irq_entry[0] && q.mode[4] |=> ext_irq_flag_clear[0]) // R18
		else $error("irq 2 flag not cleared");
	hw_clear_irq3_a: assert property (ext_irq_entry[1] && q.mode[5] |=> ext_irq_flag_clear[1]) // R18
		else $error("irq 3 flag not cleared");
	hw_clear_irq4_a: assert property (ext_irq_entry[2] && q.mode[6] |=> ext_irq_flag_clear[2]) // R18
		else $error("irq 4 flag not cleared");
	hw_clear_irq5_a: assert property (ext_irq_entry[3] && q.mode[7] |=> ext_irq_flag_clear[3]) // R18
		else $error("irq 5 flag not cleared");
	hw_clear_off_a: assert property (!q.mode[4] |=> !ext_irq_flag_clear[0]) // R18
		else $error("irq 2 flag cleared while hardware clear is off");

	// a software write in the data phase owns the count, so those cycles are left out below
	cap_reset_clear_a: assert property (trig_event && tmode == CAPTURE_RESET_ENABLE_CAPTURE && q.mode[3] && !q.wr_pend
		|=> q.cnt == 16'h0000) // R14
		else $error("count not cleared after capture");
	capture_keeps_a: assert property (trig_event && tmode == CAPTURE_RESET_ENABLE_CAPTURE && !q.mode[3] && !tick
		&& !q.wr_pend |=> $stable(q.cnt)) // R13
		else $error("capture without reset disturbed the count");
	trigger_reload_a: assert property (trig_event && tmode == CAPTURE_RESET_ENABLE_RELOAD && !q.wr_pend
		|=> q.cnt == $past(q.cap)) // R12 R17
		else $error("no reload on trigger fall");
	baud_reload_a: assert property (ovf && baud && !q.wr_pend |=> q.cnt == $past(q.cap)) // R11 R20
		else $error("no reload on baud overflow");
	baud_no_trigger_a: assert property (baud |-> !trig_event) // R7
		else $error("trigger acted in baud mode");
	up_step_a: assert property (tick && !down && !ovf && !trig_event && !q.wr_pend
		|=> q.cnt == $past(q.cnt) + 16'h0001) // R10
		else $error("count did not step up");
	down_step_a: assert property (tick && down && !ovf && !q.wr_pend
		|=> q.cnt == $past(q.cnt) - 16'h0001) // R16 R19
		else $error("count did not step down");
	underflow_wrap_a: assert property (ovf && down && !q.wr_pend |=> q.cnt == 16'hffff) // R19
		else $error("down count did not wrap at capture value");
	updown_toggle_a: assert property (ovf && tmode == CAPTURE_RESET_ENABLE_UPDOWN && !q.wr_pend
		|=> q.ctrl[6] != $past(q.ctrl[6])) // R19
		else $error("external flag did not toggle on up-down overflow");
	counter_pin_a: assert property (run && q.ctrl[1] && !baud |-> tick == pin_fall[0]) // R10
		else $error("counter mode tick not from count pin fall");
	prescale_hold_a: assert property (!run |=> $stable(q.pre)) // R8
		else $error("prescaler moved while stopped");
	clock_out_toggle_a: assert property (ovf && q.mode[1] |=> clock_out != $past(clock_out)) // R15
		else $error("clock out did not toggle on overflow");
	clock_out_hold_a: assert property (!q.mode[1] |=> $stable(clock_out)) // R15
		else $error("clock out moved while disabled");
	tx_tick_a: assert property (ovf && q.ctrl[4] |=> tx_baud_tick) // R6 R20
		else $error("transmit baud tick missing");
	no_tx_tick_a: assert property (!q.ctrl[4] |=> !tx_baud_tick) // R6
		else $error("transmit baud tick without transmit select");
	no_rx_tick_a: assert property (!q.ctrl[5] |=> !rx_baud_tick) // R5
		else $error("receive baud tick without receive select");
	// flags are sticky: only a write, or an up-down overflow for the external flag, may take them down
	ovf_flag_stays_a: assert property (q.ctrl[7] && !q.wr_pend |=> q.ctrl[7]) // R2
		else $error("overflow flag cleared by hardware");
	ext_flag_stays_a: assert property (q.ctrl[6] && !q.wr_pend && !(ovf && tmode == CAPTURE_RESET_ENABLE_UPDOWN)
		|=> q.ctrl[6]) // R3
		else $error("external flag cleared by hardware");
	irq_follows_a: assert property (q.irq == (q.ctrl[7] | q.ctrl[6])) // R4
		else $error("interrupt request does not follow the flags");

	cov_capture_c: cover property (trig_event && tmode == CAPTURE_RESET_ENABLE_CAPTURE);
	cov_baud_c:    cover property (ovf && baud);
	cov_down_c:    cover property (ovf && down);
	cov_clkout_c:  cover property ($rose(clock_out));
	cov_reload_c:  cover property (trig_event && tmode == CAPTURE_RESET_ENABLE_RELOAD);
endmodule // capture_reset_enable_timer

// ---- sim/capture_reset_enable_pin_model.sv ----
// far-side model: drives the count pin and the capture trigger pin
`timescale 1ns/1ps
module capture_reset_enable_pin_model (
	// clock
	input  wire logic clk,
	// pins
	output logic      count_pin,
	output logic      trigger_pin
);
	initial begin
		count_pin = 1'h1;
		trigger_pin = 1'h1;
	end
	// each low level lasts 4 clocks and each high level at least 5, above the 2-clock minimum of the synchroniser
	task automatic count_falls(input int n);
		repeat (n) begin
			@(posedge clk) count_pin <= 1'h0;
			repeat (4) @(posedge clk);
			count_pin <= 1'h1;
			repeat (4) @(posedge clk);
		end
	endtask
	task automatic trig_level(input logic lvl);
		@(posedge clk) trigger_pin <= lvl;
	endtask
	task automatic trig_fall();
		trig_level(1'h0);
		repeat (4) @(posedge clk);
		trigger_pin <= 1'h1;
		repeat (6) @(posedge clk);
	endtask
endmodule // capture_reset_enable_pin_model

// ---- sim/testbench.sv ----
// self-checking bench for the timer 2 block
`timescale 1ns/1ps
`include "capture_reset_enable_defines.svh"
module testbench;
	localparam logic [7:0] CTL = `CAPTURE_RESET_ENABLE_IDX_CONTROL;
	localparam logic [7:0] MD  = `CAPTURE_RESET_ENABLE_IDX_MODE;
	localparam logic [7:0] CPL = `CAPTURE_RESET_ENABLE_IDX_CAP_LOW;
	localparam logic [7:0] CPH = `CAPTURE_RESET_ENABLE_IDX_CAP_HIGH;
	localparam logic [7:0] CNL = `CAPTURE_RESET_ENABLE_IDX_COUNT_LOW;
	localparam logic [7:0] CNH = `CAPTURE_RESET_ENABLE_IDX_COUNT_HIGH;
	logic        clk = 1'h0;
	logic        srst = 1'h1;
	logic        hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'h0;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic        count_pin;
	logic        trigger_pin;
	logic        speed = 1'h1;
	logic [3:0]  entry = 4'h0;
	logic        irq;
	logic [3:0]  clr;
	logic        rx_tick;
	logic        tx_tick;
	logic        rx_use;
	logic        tx_use;
	logic        clock_out;
	int          bad_count = 0;
	int          n_compared = 0;
	logic [7:0]  v;
	int          gap;
	logic        co;

	always #2 clk = ~clk;

	capture_reset_enable_timer i_capture_reset_enable_timer (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .count_pin(count_pin), .trigger_pin(trigger_pin),
		.timer_speed_bit(speed), .ext_irq_entry(entry), .timer_irq(irq), .ext_irq_flag_clear(clr),
		.rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .rx_use_timer2(rx_use),
		.tx_use_timer2(tx_use), .clock_out(clock_out));
	capture_reset_enable_pin_model i_capture_reset_enable_pin_model (.clk(clk), .count_pin(count_pin), .trigger_pin(trigger_pin));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// single word transfer; waits on hready rather than assuming a latency
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk);
		hsel <= 1'h1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata[7:0];
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] unused;
		bus(1'h1, idx, d, unused);
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] got;
		bus(1'h0, idx, 8'h0, got);
		chk({8'h0, got}, {8'h0, exp});
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim();
	end

	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		for (int i = 0; i < 7; i++) rc(CTL + i[7:0], 8'h0);
		wr(8'hce, 8'h5a);
		rc(8'hce, 8'h0);
		wr(MD, 8'hff);
		rc(MD, 8'hfb);
		chk({15'h0, hresp}, 16'h0);
		wr(CTL, 8'h80);
		rc(CTL, 8'h80);
		chk({15'h0, irq}, 16'h1);
		wr(CTL, 8'h00);
		rc(CTL, 8'h00);
		done("registers");
		// hardware clear of external interrupt flags, then with clears disabled
		wr(MD, 8'hf0);
		for (int b = 0; b < 5; b++) begin
			if (b == 4) wr(MD, 8'h00);
			@(posedge clk) entry <= 4'h1 << b[1:0];
			@(posedge clk) entry <= 4'h0;
			@(negedge clk);
			chk({12'h0, clr}, (b == 4) ? 16'h0 : 16'h1 << b);
		end
		done("irq_clear");
		// auto-reload on overflow, then stop and hold
		wr(CPL, 8'h00);
		wr(CPH, 8'h12);
		wr(CNL, 8'hfe);
		wr(CNH, 8'hff);
		wr(CTL, 8'h04);
		repeat (40) @(posedge clk);
		rc(CTL, 8'h84);
		wr(CTL, 8'h00);
		rc(CNH, 8'h12);
		bus(1'h0, CNL, 8'h0, v);
		repeat (40) @(posedge clk);
		rc(CNL, v);
		done("reload");
		// slow timer rate: reload value ffff makes every tick overflow and toggle clock_out
		speed <= 1'h0;
		wr(MD, 8'h02);
		wr(CPL, 8'hff);
		wr(CPH, 8'hff);
		wr(CNL, 8'hff);
		wr(CNH, 8'hff);
		wr(CTL, 8'h04);
		co = clock_out;
		do @(negedge clk); while (clock_out === co);
		co = clock_out;
		gap = 0;
		do begin
			@(negedge clk);
			gap++;
		end while (clock_out === co && gap < 200);
		chk(gap[15:0], 16'd12);
		wr(CTL, 8'h00);
		speed <= 1'h1;
		done("slow_rate");
		// counter mode counts count-pin falls
		wr(CNL, 8'h00);
		wr(CNH, 8'h00);
		wr(CTL, 8'h06);
		i_capture_reset_enable_pin_model.count_falls(5);
		wr(CTL, 8'h00);
		rc(CNL, 8'h05);
		done("counter");
		// capture with capture reset, then trigger disabled
		wr(MD, 8'h08);
		wr(CNL, 8'h56);
		wr(CNH, 8'h34);
		wr(CTL, 8'h09);
		i_capture_reset_enable_pin_model.trig_fall();
		chk({15'h0, irq}, 16'h1);
		rc(CPL, 8'h56);
		rc(CPH, 8'h34);
		rc(CNL, 8'h00);
		rc(CNH, 8'h00);
		rc(CTL, 8'h49);
		wr(CTL, 8'h01);
		wr(CNL, 8'h11);
		i_capture_reset_enable_pin_model.trig_fall();
		rc(CPL, 8'h56);
		rc(CTL, 8'h01);
		done("capture");
		// reload from a trigger fall
		wr(MD, 8'h00);
		wr(CTL, 8'h08);
		i_capture_reset_enable_pin_model.trig_fall();
		rc(CNL, 8'h56);
		rc(CNH, 8'h34);
		rc(CTL, 8'h48);
		done("trigger_reload");
		// down count with trigger low: underflow at capture value
		wr(MD, 8'h01);
		wr(CPL, 8'h10);
		wr(CPH, 8'h00);
		wr(CNL, 8'h12);
		wr(CNH, 8'h00);
		i_capture_reset_enable_pin_model.trig_level(1'h0);
		wr(CTL, 8'h04);
		repeat (40) @(posedge clk);
		rc(CTL, 8'hc4);
		wr(CTL, 8'h00);
		rc(CNH, 8'hff);
		i_capture_reset_enable_pin_model.trig_level(1'h1);
		done("down_count");
		// baud mode: 16 ticks of 2 clocks per overflow, capture select ignored
		wr(MD, 8'h02);
		wr(CPL, 8'hf0);
		wr(CPH, 8'hff);
		wr(CTL, 8'h35);
		do @(negedge clk); while (rx_tick !== 1'h1);
		co = clock_out;
		chk({15'h0, tx_tick}, 16'h1);
		gap = 0;
		do begin
			@(negedge clk);
			gap++;
		end while (rx_tick !== 1'h1 && gap < 200);
		chk(gap[15:0], 16'd32);
		chk({15'h0, clock_out}, {15'h0, ~co});
		chk({14'h0, rx_use, tx_use}, 16'h3);
		rc(CTL, 8'h35);
		wr(CTL, 8'h24);
		gap = 0;
		repeat (80) @(negedge clk) gap += int'(tx_tick === 1'h1);
		chk(gap[15:0], 16'h0);
		chk({14'h0, rx_use, tx_use}, 16'h2);
		done("baud");
		end_sim();
	end
endmodule // testbench
